// File: mbd_bonding_deskew.sv
`timescale 1ns/1ns
`default_nettype none
module mbd_bonding_deskew #(
    parameter int NUM_CH = mbd_pkg::DEF_CH,
    parameter int NUM_MAC = mbd_pkg::DEF_MAC,
    parameter int ROWS = mbd_pkg::DEF_ROWS,
    parameter int MAC_W = (NUM_MAC > 1) ? $clog2(NUM_MAC) : 1,
    parameter int LANE_W = $clog2(NUM_CH + 1),
    parameter int ROW_W = $clog2(ROWS)
) (
    // System clock side
    input wire logic clock,
    input wire logic rst_b,
    input wire logic linkEnable,
    output logic [mbd_pkg::HDR_CNT_W-1:0] headerCount,
    // Link clock, shared by all transmit and receive channels
    input wire logic linkClk,
    // Envelope requests, one per transmit channel
    input wire logic [NUM_CH-1:0] envReq,
    input wire mbd_pkg::mbd_env_s [NUM_CH-1:0] envInfo,
    input wire logic [NUM_CH-1:0][MAC_W-1:0] envMac,
    output logic [NUM_CH-1:0] envReady,
    // MAC transmit lanes, lane 0 consumed first
    input wire logic [NUM_MAC-1:0][NUM_CH-1:0][mbd_pkg::EQ_W-1:0] macTxData,
    output logic [NUM_MAC-1:0][LANE_W-1:0] macTxTake,
    // Transmit and receive channel buses
    output var mbd_pkg::mbd_xfer_s [NUM_CH-1:0] txXfer,
    input wire mbd_pkg::mbd_xfer_s [NUM_CH-1:0] rxXfer,
    // MAC receive lanes
    output logic [NUM_MAC-1:0][NUM_CH-1:0][mbd_pkg::EQ_W-1:0] macRxData,
    output logic [NUM_MAC-1:0][LANE_W-1:0] macRxCount
);
    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (NUM_CH < 1 || NUM_MAC < 1) begin : g_chk_cnt
        $error("channel and MAC counts must be at least one");
    end
    if ((1 << ROW_W) != ROWS || ROW_W > mbd_pkg::EPAM_W) begin : g_chk_rows
        $error("rows must be a power of two fitting the marker field");
    end
    if (mbd_pkg::RX_LAG >= ROWS) begin : g_chk_lag
        $error("receive lag must be below the buffer depth");
    end

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic rstHold_r;
    logic enHold_r;
    logic [1:0] rstSync_r;
    logic [1:0] enSync_r;
    logic linkRstB;
    logic linkEn;
    logic phase_r;
    logic [ROW_W-1:0] txWr_r;
    logic [ROW_W-1:0] txRd_r;
    logic [mbd_pkg::EQ_W-1:0] txBuf_r [ROWS][NUM_CH];
    logic [NUM_CH-1:0] envPend_r;
    mbd_pkg::mbd_env_s [NUM_CH-1:0] envHeld_r;
    logic [NUM_CH-1:0][MAC_W-1:0] txMac_r;
    logic [NUM_CH-1:0][mbd_pkg::LEN_W-1:0] txRemain_r;
    logic [NUM_CH-1:0][mbd_pkg::EQ_W-1:0] rowEq;
    logic [NUM_MAC-1:0][LANE_W-1:0] txCnt;
    logic rxRun_r;
    logic [ROW_W-1:0] rxRd_r;
    logic rdStrobe;
    logic [NUM_CH-1:0] hdrHit;
    logic [NUM_CH-1:0][ROW_W-1:0] hdrRow;
    logic [NUM_CH-1:0][mbd_pkg::EQ_W-1:0] rdEq;
    logic [NUM_CH-1:0] rdValid;
    logic [NUM_CH-1:0][MAC_W-1:0] rdMac;
    logic [NUM_MAC-1:0][LANE_W-1:0] rxCnt;
    logic [NUM_MAC-1:0][NUM_CH-1:0][mbd_pkg::EQ_W-1:0] rxLane;
    logic [ROW_W-1:0] firstRow;
    logic [mbd_pkg::HDR_CNT_W-1:0] hdrBin_r;
    logic [mbd_pkg::HDR_CNT_W-1:0] hdrBinNxt;
    logic [mbd_pkg::HDR_CNT_W-1:0] hdrGray_r;
    logic [mbd_pkg::HDR_CNT_W-1:0] grayS1_r;
    logic [mbd_pkg::HDR_CNT_W-1:0] grayS2_r;

    // ----------------------------------------------------------------
    // Header builder
    // ----------------------------------------------------------------
    function automatic logic [mbd_pkg::EQ_W-1:0] makeHeader(
        input mbd_pkg::mbd_env_s env,
        input logic [ROW_W-1:0] row
    );
        logic [mbd_pkg::EQ_W-1:0] h;
        h = '0;
        h[mbd_pkg::CTRL_LSB +: 8] = mbd_pkg::HDR_CTRL;
        h[mbd_pkg::START_LSB +: 8] = mbd_pkg::START_CODE;
        h[mbd_pkg::TYPE_BIT] = 1'b1; // Start header
        h[mbd_pkg::LEN_LSB +: mbd_pkg::LEN_W] = env.len;
        h[mbd_pkg::EPAM_LSB +: ROW_W] = row;
        h[mbd_pkg::LOGICAL_LINK_ID_LSB +: mbd_pkg::LOGICAL_LINK_ID_W] = env.logical_link_id;
        return h;
    endfunction

    // Gray to binary for the header counter crossing
    function automatic logic [mbd_pkg::HDR_CNT_W-1:0] grayToBin(
        input logic [mbd_pkg::HDR_CNT_W-1:0] g
    );
        logic [mbd_pkg::HDR_CNT_W-1:0] b;
        b = '0;
        b[mbd_pkg::HDR_CNT_W-1] = g[mbd_pkg::HDR_CNT_W-1];
        for (int i = mbd_pkg::HDR_CNT_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // ----------------------------------------------------------------
    // System side: hold reset and enable, collect header count
    // ----------------------------------------------------------------
    // Registered first so only a flop drives the crossing
    always_ff @(posedge clock) begin
        rstHold_r <= rst_b;
        if (!rst_b) begin
            enHold_r <= 1'b0;
        end else begin
            enHold_r <= linkEnable;
        end
    end

    // Gray count crosses safely; only one bit moves per step
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            grayS1_r <= '0;
            grayS2_r <= '0;
            headerCount <= '0;
        end else begin
            grayS1_r <= hdrGray_r;
            grayS2_r <= grayS1_r;
            headerCount <= grayToBin(grayS2_r);
        end
    end

    // ----------------------------------------------------------------
    // Link side: synchronisers and transfer phase
    // ----------------------------------------------------------------
    // Level crossings; the first stage feeds only the second
    always_ff @(posedge linkClk) begin
        rstSync_r <= {rstSync_r[0], rstHold_r};
        enSync_r <= {enSync_r[0], enHold_r};
    end
    assign linkRstB = rstSync_r[1];
    assign linkEn = enSync_r[1];

    // Two transfers per quantum; phase 0 is the row cycle
    always_ff @(posedge linkClk) begin
        if (!linkRstB) begin
            phase_r <= 1'b0;
        end else begin
            phase_r <= ~phase_r;
        end
    end

    // ----------------------------------------------------------------
    // Transmit: build one row of quanta
    // ----------------------------------------------------------------
    // Columns walk upward, so a MAC's lanes fill low channel first
    always_comb begin
        txCnt = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            rowEq[c] = mbd_pkg::IDLE_EQ;
            if (linkEn) begin
                if (txRemain_r[c] != '0) begin
                    rowEq[c] = macTxData[txMac_r[c]][txCnt[txMac_r[c]]];
                    txCnt[txMac_r[c]] = LANE_W'(txCnt[txMac_r[c]] + 1'b1);
                end else if (envPend_r[c]) begin
                    rowEq[c] = makeHeader(envHeld_r[c], txWr_r);
                end
            end
        end
    end

    // Envelope bookkeeping per channel; one request waits at a time
    always_ff @(posedge linkClk) begin
        if (!linkRstB) begin
            envPend_r <= '0;
            envReady <= '0;
            envHeld_r <= '0;
            txMac_r <= '0;
            txRemain_r <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (!envPend_r[c]) begin
                    envReady[c] <= ~envReq[c];
                    if (envReq[c]) begin
                        envPend_r[c] <= 1'b1;
                        envHeld_r[c] <= envInfo[c];
                    end
                end
                if (!phase_r && linkEn) begin
                    if (txRemain_r[c] != '0) begin
                        txRemain_r[c] <= txRemain_r[c] - 1'b1;
                    end else if (envPend_r[c]) begin
                        // Header counts as one quantum of the length
                        txRemain_r[c] <= (envHeld_r[c].len == '0) ? '0 :
                                         envHeld_r[c].len - 1'b1;
                        txMac_r[c] <= envMac[c];
                        envPend_r[c] <= 1'b0;
                        envReady[c] <= 1'b1;
                    end
                end
            end
        end
    end

    // Whole row written at once, then the write row moves on
    always_ff @(posedge linkClk) begin
        if (!linkRstB) begin
            txWr_r <= '0;
            for (int r = 0; r < ROWS; r++) begin
                for (int c = 0; c < NUM_CH; c++) begin
                    txBuf_r[r][c] <= mbd_pkg::IDLE_EQ;
                end
            end
        end else if (!phase_r) begin
            for (int c = 0; c < NUM_CH; c++) begin
                txBuf_r[txWr_r][c] <= rowEq[c];
            end
            txWr_r <= ROW_W'(txWr_r + 1'b1);
        end
    end

    // Take counts show for the phase 1 cycle only
    always_ff @(posedge linkClk) begin
        if (!linkRstB) begin
            macTxTake <= '0;
        end else if (!phase_r) begin
            macTxTake <= txCnt;
        end else begin
            macTxTake <= '0;
        end
    end

    // Read row trails the write row by one; same clock for all channels
    always_ff @(posedge linkClk) begin
        if (!linkRstB) begin
            txRd_r <= ROW_W'(ROWS - 1);
            txXfer <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (!phase_r) begin
                    txXfer[c].xc <= txBuf_r[txRd_r][c][3:0];
                    txXfer[c].xd <= txBuf_r[txRd_r][c][39:8];
                end else begin
                    txXfer[c].xc <= txBuf_r[txRd_r][c][7:4];
                    txXfer[c].xd <= txBuf_r[txRd_r][c][71:40];
                end
            end
            if (phase_r) begin
                txRd_r <= ROW_W'(txRd_r + 1'b1);
            end
        end
    end

    // ----------------------------------------------------------------
    // Receive: one column per channel
    // ----------------------------------------------------------------
    for (genvar c = 0; c < NUM_CH; c++) begin : g_rxcol
        logic [mbd_pkg::EQ_W-1:0] cell_r [ROWS];
        logic [ROWS-1:0] valid_r;
        logic [MAC_W-1:0] cellMac_r [ROWS];
        mbd_pkg::mbd_xfer_s half_r;
        logic have_r;
        logic [ROW_W-1:0] wr_r;
        logic [MAC_W-1:0] mac_r;
        logic [mbd_pkg::LEN_W-1:0] remain_r;
        logic [mbd_pkg::EQ_W-1:0] eq;
        logic isHdr;
        logic [ROW_W-1:0] nxtRow;

        assign eq = {rxXfer[c].xd, half_r.xd, rxXfer[c].xc, half_r.xc};
        assign isHdr = have_r && eq[mbd_pkg::CTRL_LSB +: 8] == mbd_pkg::HDR_CTRL &&
                       eq[mbd_pkg::START_LSB +: 8] == mbd_pkg::START_CODE;
        assign nxtRow = ROW_W'(wr_r + 1'b1);
        assign hdrHit[c] = linkEn & isHdr;
        assign hdrRow[c] = eq[mbd_pkg::EPAM_LSB +: ROW_W];
        assign rdEq[c] = cell_r[rxRd_r];
        assign rdValid[c] = valid_r[rxRd_r];
        assign rdMac[c] = cellMac_r[rxRd_r];

        // Outside an envelope only a header start re-aligns the pair
        always_ff @(posedge linkClk) begin
            if (!linkRstB) begin
                valid_r <= '0;
                half_r <= '0;
                have_r <= 1'b0;
                wr_r <= '0;
                mac_r <= '0;
                remain_r <= '0;
                for (int r = 0; r < ROWS; r++) begin
                    cell_r[r] <= '0;
                    cellMac_r[r] <= '0;
                end
            end else begin
                if (rdStrobe) begin
                    valid_r[rxRd_r] <= 1'b0;
                end
                if (!linkEn) begin
                    have_r <= 1'b0;
                end else if (!have_r) begin
                    if (remain_r != '0 || (rxXfer[c].xc == mbd_pkg::XC_DATA &&
                        rxXfer[c].xd[7:0] == mbd_pkg::START_CODE)) begin
                        half_r <= rxXfer[c];
                        have_r <= 1'b1;
                    end
                end else begin
                    have_r <= 1'b0;
                    if (isHdr) begin
                        // Marker row reloads the write row; start headers stay local
                        wr_r <= hdrRow[c];
                        cell_r[hdrRow[c]] <= mbd_pkg::PREAMBLE_EQ;
                        valid_r[hdrRow[c]] <= ~eq[mbd_pkg::TYPE_BIT];
                        mac_r <= eq[mbd_pkg::LOGICAL_LINK_ID_LSB +: MAC_W];
                        cellMac_r[hdrRow[c]] <= eq[mbd_pkg::LOGICAL_LINK_ID_LSB +: MAC_W];
                        remain_r <= (eq[mbd_pkg::LEN_LSB +: mbd_pkg::LEN_W] == '0) ? '0 :
                                    eq[mbd_pkg::LEN_LSB +: mbd_pkg::LEN_W] - 1'b1;
                    end else if (remain_r != '0) begin
                        wr_r <= nxtRow;
                        cell_r[nxtRow] <= eq;
                        valid_r[nxtRow] <= 1'b1;
                        cellMac_r[nxtRow] <= mac_r;
                        remain_r <= remain_r - 1'b1;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Receive readout
    // ----------------------------------------------------------------
    // Lowest hit column seeds the read row
    always_comb begin
        firstRow = '0;
        for (int c = NUM_CH - 1; c >= 0; c--) begin
            if (hdrHit[c]) begin
                firstRow = hdrRow[c];
            end
        end
    end

    assign rdStrobe = rxRun_r & ~phase_r;

    // Fixed lag gives slow channels time to fill the row before it is read
    always_ff @(posedge linkClk) begin
        if (!linkRstB) begin
            rxRun_r <= 1'b0;
            rxRd_r <= '0;
        end else if (!rxRun_r) begin
            if (|hdrHit) begin
                rxRun_r <= 1'b1;
                rxRd_r <= ROW_W'(firstRow - ROW_W'(mbd_pkg::RX_LAG));
            end
        end else if (!phase_r) begin
            rxRd_r <= ROW_W'(rxRd_r + 1'b1);
        end
    end

    // Same-MAC cells packed into lanes, lower column first
    always_comb begin
        rxCnt = '0;
        rxLane = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            if (rdValid[c]) begin
                rxLane[rdMac[c]][rxCnt[rdMac[c]]] = rdEq[c];
                rxCnt[rdMac[c]] = LANE_W'(rxCnt[rdMac[c]] + 1'b1);
            end
        end
    end

    // Delivered lanes hold until the next row; the count marks one cycle
    always_ff @(posedge linkClk) begin
        if (!linkRstB) begin
            macRxData <= '0;
            macRxCount <= '0;
        end else if (rdStrobe) begin
            macRxData <= rxLane;
            macRxCount <= rxCnt;
        end else begin
            macRxCount <= '0;
        end
    end

    // ----------------------------------------------------------------
    // Header counter toward the system side
    // ----------------------------------------------------------------
    // Counts cycles with a header, so the gray code moves one step at most
    assign hdrBinNxt = mbd_pkg::HDR_CNT_W'(hdrBin_r + 1'b1);

    always_ff @(posedge linkClk) begin
        if (!linkRstB) begin
            hdrBin_r <= '0;
            hdrGray_r <= '0;
        end else if (|hdrHit) begin
            hdrBin_r <= hdrBinNxt;
            hdrGray_r <= hdrBinNxt ^ (hdrBinNxt >> 1);
        end
    end
endmodule
`default_nettype wire

// File: mbd_pkg.sv
package mbd_pkg;
    // ----------------------------------------------------------------
    // Quantum and transfer geometry
    // ----------------------------------------------------------------
    localparam int EQ_W = 72;
    localparam int XD_W = 32;
    localparam int XC_W = 4;
    localparam int DEF_ROWS = 32;
    localparam int DEF_CH = 4;
    localparam int DEF_MAC = 4;
    // ----------------------------------------------------------------
    // Header field positions
    // ----------------------------------------------------------------
    localparam int CTRL_LSB = 0;
    localparam int START_LSB = 8;
    localparam int TYPE_BIT = 16;
    localparam int LEN_LSB = 18;
    localparam int LEN_W = 22;
    localparam int EPAM_LSB = 40;
    localparam int EPAM_W = 6;
    localparam int LOGICAL_LINK_ID_LSB = 48;
    localparam int LOGICAL_LINK_ID_W = 16;
    // ----------------------------------------------------------------
    // Codes and fill values
    // ----------------------------------------------------------------
    localparam logic [7:0] HDR_CTRL = 8'h80;
    localparam logic [7:0] START_CODE = 8'hFB;
    localparam logic [XC_W-1:0] XC_DATA = 4'h0;
    localparam logic [EQ_W-1:0] IDLE_EQ = 72'hFF_0808080808080808;
    localparam logic [EQ_W-1:0] PREAMBLE_EQ = 72'h01_D5555555555555FB;
    // ----------------------------------------------------------------
    // Timing counts, in buffer rows and counter widths
    // ----------------------------------------------------------------
    localparam int RX_LAG = 16;
    localparam int HDR_CNT_W = 16;
    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [LOGICAL_LINK_ID_W-1:0] logical_link_id;
        logic [LEN_W-1:0] len;
    } mbd_env_s;
    typedef struct packed {
        logic [XC_W-1:0] xc;
        logic [XD_W-1:0] xd;
    } mbd_xfer_s;
endpackage

// File: mbd_checker.sv
`timescale 1ns/1ns
`default_nettype none
module mbd_checker #(
    parameter int NUM_CH = 2,
    parameter int NUM_MAC = 2,
    parameter int LANE_W = 2
) (
    // Link side
    input wire logic linkClk,
    input wire logic rst_b,
    input wire logic [NUM_CH-1:0] envReq,
    input wire logic [NUM_CH-1:0] envReady,
    // Lanes and channels
    input wire logic [NUM_MAC-1:0][LANE_W-1:0] macTxTake,
    input wire logic [NUM_MAC-1:0][LANE_W-1:0] macRxCount,
    input wire mbd_pkg::mbd_xfer_s [NUM_CH-1:0] txXfer
);
    // ----
    // Link domain checks
    // ----
    default clocking cb @(posedge linkClk);
    endclocking
    default disable iff (!rst_b);
    property p_take_pulse; macTxTake[0] != '0 |=> macTxTake[0] == '0; endproperty
    a_take_pulse: assert property (p_take_pulse) else $error("take held two cycles");
    property p_rx_pulse; macRxCount[1] != '0 |=> macRxCount[1] == '0; endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("row read twice");
    property p_rx_max; macRxCount[0] <= NUM_CH; endproperty
    a_rx_max: assert property (p_rx_max) else $error("more lanes than columns");
    property p_ready_drop; envReq[0] && envReady[0] |=> !envReady[0]; endproperty
    a_ready_drop: assert property (p_ready_drop) else $error("request not taken");
    property p_ready_back; envReq[1] && envReady[1] |=> !envReady[1] ##[1:3] envReady[1]; endproperty
    a_ready_back: assert property (p_ready_back) else $error("header never placed");
    property p_hdr_pair;
        txXfer[0].xc == 4'h0 && txXfer[0].xd[7:0] == 8'hFB |=> txXfer[0].xc == 4'h8;
    endproperty
    a_hdr_pair: assert property (p_hdr_pair) else $error("header halves split");
    property p_marker_same;
        txXfer[0].xc == 4'h0 && txXfer[0].xd[7:0] == 8'hFB && txXfer[1].xc == 4'h0
            && txXfer[1].xd[7:0] == 8'hFB |=> txXfer[0].xd[5:0] == txXfer[1].xd[5:0];
    endproperty
    a_marker_same: assert property (p_marker_same) else $error("row markers differ");
    property p_idle_pair; txXfer[1] == 36'h808080808 |=> txXfer[1] == 36'h0FF080808; endproperty
    a_idle_pair: assert property (p_idle_pair) else $error("idle quantum broken");
endmodule
bind mbd_bonding_deskew mbd_checker #(.NUM_CH(NUM_CH), .NUM_MAC(NUM_MAC), .LANE_W(LANE_W))
    i_mbd_checker (.linkClk(linkClk), .rst_b(rst_b), .envReq(envReq), .envReady(envReady),
    .macTxTake(macTxTake), .macRxCount(macRxCount), .txXfer(txXfer));
`default_nettype wire

// File: mbd_far_end.sv
`timescale 1ns/1ns
`default_nettype none
module mbd_far_end #(
    parameter int NUM_CH = 2,
    parameter int NUM_MAC = 2,
    parameter int LANE_W = 2
) (
    // Shared link clock
    input wire logic linkClk,
    // MAC transmit sources
    input wire logic [NUM_MAC-1:0][LANE_W-1:0] macTxTake,
    output logic [NUM_MAC-1:0][NUM_CH-1:0][mbd_pkg::EQ_W-1:0] macTxData,
    // Channel loopback
    input wire mbd_pkg::mbd_xfer_s [NUM_CH-1:0] txXfer,
    output mbd_pkg::mbd_xfer_s [NUM_CH-1:0] rxXfer
);
    logic [NUM_MAC-1:0][15:0] seq_r = '0;
    mbd_pkg::mbd_xfer_s [NUM_CH-1:0][7:0] pipe_r = '0;
    // Sources shift by what was taken; fibres delay channel c by 3c+1 transfers
    always @(posedge linkClk) begin
        for (int m = 0; m < NUM_MAC; m++) begin
            seq_r[m] <= seq_r[m] + 16'(macTxTake[m]);
        end
        for (int c = 0; c < NUM_CH; c++) begin
            pipe_r[c] <= {pipe_r[c][6:0], txXfer[c]};
        end
    end
    // Sequence number on top, MAC index below; low bytes zero so no false start
    always_comb begin
        for (int m = 0; m < NUM_MAC; m++) begin
            for (int l = 0; l < NUM_CH; l++) begin
                macTxData[m][l] = {seq_r[m] + 16'(l), 8'(m), 48'h0};
            end
        end
        for (int c = 0; c < NUM_CH; c++) begin
            rxXfer[c] = pipe_r[c][3*c];
        end
    end
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clock = 1'b0;
    logic linkClk = 1'b0;
    logic rst_b = 1'b0;
    logic linkEnable = 1'b0;
    logic [15:0] headerCount;
    logic [1:0] envReq;
    mbd_pkg::mbd_env_s [1:0] envInfo;
    logic [1:0][0:0] envMac;
    logic [1:0] envReady;
    logic [1:0][1:0][71:0] macTxData;
    logic [1:0][1:0][71:0] macRxData;
    logic [1:0][1:0] macTxTake;
    logic [1:0][1:0] macRxCount;
    mbd_pkg::mbd_xfer_s [1:0] txXfer;
    mbd_pkg::mbd_xfer_s [1:0] rxXfer;
    int n_mismatch = 0;
    int checks_done = 0;
    int got [2];
    logic [15:0] expSeq [2] = '{16'h0, 16'h0};
    // ----
    // Clocks and instances
    // ----
    always #10 clock = ~clock;
    initial begin
        #1;
        forever #3 linkClk = ~linkClk;
    end
    mbd_bonding_deskew #(.NUM_CH(2), .NUM_MAC(2)) i_mbd_bonding_deskew (.clock(clock),
        .rst_b(rst_b), .linkEnable(linkEnable), .headerCount(headerCount), .linkClk(linkClk),
        .envReq(envReq), .envInfo(envInfo), .envMac(envMac), .envReady(envReady),
        .macTxData(macTxData), .macTxTake(macTxTake), .txXfer(txXfer), .rxXfer(rxXfer),
        .macRxData(macRxData), .macRxCount(macRxCount));
    mbd_far_end #(.NUM_CH(2), .NUM_MAC(2), .LANE_W(2)) i_mbd_far_end (.linkClk(linkClk),
        .macTxTake(macTxTake), .macTxData(macTxData), .txXfer(txXfer), .rxXfer(rxXfer));
    // ----
    // Checking helpers
    // ----
    task automatic check(input logic [71:0] seen, input logic [71:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Every delivered lane must carry its MAC's next quantum, lane 0 first
    always @(negedge linkClk) begin
        for (int m = 0; m < 2; m++) begin
            for (int l = 0; l < 2; l++) begin
                if (l < macRxCount[m]) begin
                    check(macRxData[m][l], {expSeq[m], 8'(m), 48'h0});
                    expSeq[m]++;
                    got[m]++;
                end
            end
        end
    end
    // Open envelopes on chosen channels together, then count what each MAC gets
    task automatic run_env(input logic [1:0] chans, input logic [15:0] id0,
        input logic [15:0] id1, input logic [21:0] len, input int exp0, input int exp1);
        int n;
        got = '{0, 0};
        n = 0;
        @(posedge linkClk);
        while (envReady !== 2'b11 && n < 400) begin
            @(posedge linkClk);
            n++;
        end
        envInfo <= {id1, len, id0, len};
        envMac <= {id1[0], id0[0]};
        envReq <= chans;
        @(posedge linkClk);
        envReq <= 2'b00;
        while ((got[0] < exp0 || got[1] < exp1) && n < 400) begin
            @(posedge linkClk);
            n++;
        end
        if (n >= 400) begin
            n_mismatch++;
            stop_test();
        end
        repeat (40) @(posedge linkClk);
        check(72'(got[0]), 72'(exp0));
        check(72'(got[1]), 72'(exp1));
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        envReq = '0;
        envInfo = '0;
        envMac = '0;
        repeat (12) @(posedge clock);
        check(72'(headerCount), 72'h0);
        check(72'(envReady), 72'h0);
        check(72'(macRxCount), 72'h0);
        rst_b <= 1'b1;
        linkEnable <= 1'b1;
        run_env(2'b11, 16'h0002, 16'h0002, 22'd5, 8, 0);
        run_env(2'b11, 16'h0002, 16'h0003, 22'd3, 2, 2);
        run_env(2'b10, 16'h0002, 16'h0003, 22'd4, 0, 3);
        repeat (10) @(posedge clock);
        check(72'(headerCount), 72'd5);
        stop_test();
    end
endmodule
`default_nettype wire
